// File: hdl/band_dvol_cfg.svh
// named constants for the two band dynamic volume stage
// assumes a 100 MHz clk and one sample tick per audio sample
`ifndef BAND_DVOL_CFG_SVH
`define BAND_DVOL_CFG_SVH
// audio and coefficient format
`define AUDIO_W       24
`define COEF_W        14
`define COEF_FRAC     13
`define SAMP_MAX      24'sh7fffff
`define SAMP_MIN      24'sh800000
// curve fields
`define PT12_W        6
`define PT3_W         5
`define SLOPE_W       7
`define SLOPE_FRAC    4
`define PT_MAX        6'h2f
`define ATT_MAX       6'h3f
`define CODES_PER_BIT 4
// gain mantissas for 0, 1.5, 3.0 and 4.5 dB down
`define GAIN_FRAC     14
`define GAIN_0        16'h4000
`define GAIN_1        16'h35d9
`define GAIN_2        16'h2d4f
`define GAIN_3        16'h2620
// lowest pole coefficient per filter, from least fc/fs
`define LOW_B_MIN     14'h2066
`define MHP_B_MIN     14'h2005
`define MLP_B_MIN     14'h28c0
// register word indices, byte offset is four times index
`define AXI_AW        8
`define NREG          13
`define IX_CTRL       4'h0
`define IX_LA         4'h1
`define IX_LB         4'h2
`define IX_HA         4'h3
`define IX_HB         4'h4
`define IX_MA         4'h5
`define IX_MB         4'h6
`define IX_LP12       4'h7
`define IX_LP3        4'h8
`define IX_LS         4'h9
`define IX_MP12       4'ha
`define IX_MP3        4'hb
`define IX_MS         4'hc
`define IX_STATUS     4'hd
// pending group bits in the status word
`define NGRP          5
`define PG_LOW        0
`define PG_MHP        1
`define PG_MLP        2
`define PG_LCRV       3
`define PG_MCRV       4
`define ERR_BIT       5
// axi responses
`define RESP_OK       2'h0
`define RESP_SLVERR   2'h2
`endif

// File: hdl/band_dvol_pkg.sv
// types shared by both ends of the band dynamic volume stage
// assumes band_dvol_cfg.svh is on the include path
`include "band_dvol_cfg.svh"
package band_dvol_pkg;
    typedef logic signed [`AUDIO_W-1:0] sample_t;
    typedef logic [`COEF_W-1:0]         coef_t;
    // control word, high bit first
    typedef struct packed {
        logic comp;
        logic dac;
        logic mlpEn;
        logic mhpEn;
        logic lowEn;
    } ctrl_t;
    typedef struct packed {
        logic [`PT12_W-1:0] y2;
        logic [`PT12_W-1:0] x2;
        logic [`PT12_W-1:0] y1;
        logic [`PT12_W-1:0] x1;
    } pt12_t;
    typedef struct packed {
        logic [`PT3_W-1:0] y3;
        logic [`PT3_W-1:0] x3;
    } pt3_t;
    typedef struct packed {
        logic [`SLOPE_W-1:0] s4;
        logic [`SLOPE_W-1:0] s3;
        logic [`SLOPE_W-1:0] s2;
        logic [`SLOPE_W-1:0] s1;
    } slope_t;
    typedef struct packed {
        slope_t s;
        pt3_t   p3;
        pt12_t  p12;
    } curve_t;
    // device end state
    typedef struct packed {
        sample_t          lowX, lowY, mhX, mhY, mlX, mlY;
        logic [5:0]       lowGain, midGain;
        sample_t          lowOut, midOut;
        logic             outValid;
    } dev_state_t;
    // controller end state
    typedef struct packed {
        logic [`NREG-1:0][31:0] shadow, live;
        logic [`NGRP-1:0]       pend;
        logic                   orderErr;
        logic                   awready, wready, awGot, wGot;
        logic [`AXI_AW-1:0]     awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready, rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } ctl_state_t;
endpackage : band_dvol_pkg

// File: hdl/band_dvol_if.sv
// configuration carrier between the controller and the band stage
// assumes both ends run on the same clk
interface band_dvol_if;
    band_dvol_pkg::ctrl_t  ctl;
    band_dvol_pkg::coef_t  lowA, lowB, mhA, mhB, mlA, mlB;
    band_dvol_pkg::curve_t lowCurve, midCurve;
    // band stage end
    modport dev (
        input ctl, lowA, lowB, mhA, mhB, mlA, mlB, lowCurve, midCurve
    );
    // controller end
    modport ctrl (
        output ctl, lowA, lowB, mhA, mhB, mlA, mlB, lowCurve, midCurve
    );
endinterface : band_dvol_if

// File: hdl/band_dynamic_volume.sv
// low and middle band dynamic volume stage ahead of the compressor
// assumes sampleTick is one clk pulse per sample, same clock domain,
// and configuration held steady by the controller end
//
// Operation
// - split bands, control each independently
// - low band first order lowpass filter
// - low filter off outputs zero data
// - low filter starts within four samples
// - low coefficients written only while gated off
// - low cutoff ratio at least 0.002
// - first two points: 1.5 dB six-bit codes
// - third point: 1.5 dB five-bit codes
// - point coordinates non-decreasing first to third
// - four seven-bit slopes, sixteenths of ratio
// - fourth point full scale, gain starts slope1
// - middle band first order highpass filter
// - highpass off bypasses at unity gain
// - middle filters start within four samples
// - middle coefficients written only while gated off
// - highpass cutoff ratio at least 0.0001
// - middle band first order lowpass filter
// - lowpass off bypasses at unity gain
// - lowpass cutoff ratio at least 0.05
// - both bypassed: unity gain, no curve
// - middle curve changed only while gated off
// - coefficients two's complement, scaled by 8192
`include "band_dvol_cfg.svh"
module band_dynamic_volume (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // configuration from the controller
    band_dvol_if.dev                     cfg,
    // audio in
    input  wire band_dvol_pkg::sample_t  sampleIn,
    input  wire logic                    sampleTick,
    // band outputs towards the compressor
    output band_dvol_pkg::sample_t       lowOut,
    output band_dvol_pkg::sample_t       midOut,
    output logic                         outValid
);

    // ************************************************
    // arithmetic helpers
    // ************************************************

    // one first order section, lowpass or highpass numerator
    function automatic band_dvol_pkg::sample_t filt(
        input band_dvol_pkg::sample_t x,
        input band_dvol_pkg::sample_t xp,
        input band_dvol_pkg::sample_t yp,
        input band_dvol_pkg::coef_t   a,
        input band_dvol_pkg::coef_t   b,
        input logic                   hp
    );
        logic signed [`AUDIO_W:0] s;
        logic signed [40:0]       pa;
        logic signed [40:0]       pb;
        logic signed [40:0]       acc;
        s   = hp ? (`AUDIO_W+1)'(x) - (`AUDIO_W+1)'(xp)
                 : (`AUDIO_W+1)'(x) + (`AUDIO_W+1)'(xp);
        pa  = $signed(a) * s;
        pb  = $signed(b) * yp;
        acc = (pa - pb) >>> `COEF_FRAC;
        // clip to the sample range
        if (acc > 41'(`SAMP_MAX)) begin
            return `SAMP_MAX;
        end else if (acc < 41'(`SAMP_MIN)) begin
            return `SAMP_MIN;
        end
        return acc[`AUDIO_W-1:0];
    endfunction : filt

    // coarse level below full scale in 1.5 dB codes
    function automatic logic [5:0] level(input band_dvol_pkg::sample_t x);
        logic [`AUDIO_W-1:0] m;
        logic [7:0]          d;
        m = x[`AUDIO_W-1] ? ~x : x;
        d = 8'((`AUDIO_W - 1) * `CODES_PER_BIT);
        for (int i = 0; i < `AUDIO_W - 1; i++) begin
            if (m[i]) begin
                d = 8'((`AUDIO_W - 2 - i) * `CODES_PER_BIT);
            end
        end
        return (d > 8'(`ATT_MAX)) ? `ATT_MAX : d[5:0];
    endfunction : level

    // attenuation the curve asks for at input level d
    function automatic logic [5:0] target(
        input logic [5:0]            d,
        input band_dvol_pkg::curve_t c
    );
        logic [13:0] o;
        logic [13:0] dd;
        dd = 14'(d);
        // segments between points, slopes in sixteenths
        if (dd >= 14'(c.p3.x3)) begin
            o = 14'(c.p3.y3) + (((dd - 14'(c.p3.x3)) * 14'(c.s.s4)) >> `SLOPE_FRAC);
        end else if (dd >= 14'(c.p12.x2)) begin
            o = 14'(c.p12.y2) + (((dd - 14'(c.p12.x2)) * 14'(c.s.s3)) >> `SLOPE_FRAC);
        end else if (dd >= 14'(c.p12.x1)) begin
            o = 14'(c.p12.y1) + (((dd - 14'(c.p12.x1)) * 14'(c.s.s2)) >> `SLOPE_FRAC);
        end else begin
            o = (dd * 14'(c.s.s1)) >> `SLOPE_FRAC;
        end
        // boost is not applied, only attenuation
        if (o <= dd) begin
            return '0;
        end
        o = o - dd;
        return (o > 14'(`ATT_MAX)) ? `ATT_MAX : o[5:0];
    endfunction : target

    // gain code the curve starts from
    function automatic logic [5:0] initGain(input band_dvol_pkg::curve_t c);
        return (c.s.s1 > 7'(`ATT_MAX)) ? `ATT_MAX : c.s.s1[5:0];
    endfunction : initGain

    // move gain one code per sample towards target
    function automatic logic [5:0] step(input logic [5:0] g, input logic [5:0] t);
        if (g < t) begin
            return g + 6'h01;
        end else if (g > t) begin
            return g - 6'h01;
        end
        return g;
    endfunction : step

    // scale a sample down by an attenuation code
    function automatic band_dvol_pkg::sample_t applyGain(
        input band_dvol_pkg::sample_t x,
        input logic [5:0]             att
    );
        logic [15:0]        m;
        logic signed [40:0] p;
        case (att[1:0])
            2'h0:    m = `GAIN_0;
            2'h1:    m = `GAIN_1;
            2'h2:    m = `GAIN_2;
            default: m = `GAIN_3;
        endcase
        p = x * $signed({1'b0, m});
        p = (p >>> `GAIN_FRAC) >>> att[5:2];
        return p[`AUDIO_W-1:0];
    endfunction : applyGain

    // ************************************************
    // state and next state
    // ************************************************

    band_dvol_pkg::dev_state_t st;
    band_dvol_pkg::dev_state_t next_st;
    band_dvol_pkg::sample_t    lowF;
    band_dvol_pkg::sample_t    hpF;
    band_dvol_pkg::sample_t    lpF;
    logic                      gate;
    logic                      lowOn;
    logic                      mhOn;
    logic                      mlOn;
    logic                      midOn;

    // per sample band processing
    always_comb begin
        next_st = st;
        next_st.outValid = 1'b0;
        // power and compressor gate every filter
        gate  = cfg.ctl.dac & cfg.ctl.comp;
        lowOn = gate & cfg.ctl.lowEn;
        mhOn  = gate & cfg.ctl.mhpEn;
        mlOn  = gate & cfg.ctl.mlpEn;
        midOn = mhOn | mlOn;
        // bands computed side by side from one input
        lowF = filt(sampleIn, st.lowX, st.lowY, cfg.lowA, cfg.lowB, 1'b0);
        hpF  = mhOn ? filt(sampleIn, st.mhX, st.mhY, cfg.mhA, cfg.mhB, 1'b1)
                    : sampleIn;
        lpF  = mlOn ? filt(hpF, st.mlX, st.mlY, cfg.mlA, cfg.mlB, 1'b0)
                    : hpF;
        if (sampleTick) begin
            next_st.outValid = 1'b1;
            // low band, zero data while off, runs on the first tick
            if (lowOn) begin
                next_st.lowX    = sampleIn;
                next_st.lowY    = lowF;
                next_st.lowGain = step(st.lowGain, target(level(lowF), cfg.lowCurve));
                next_st.lowOut  = applyGain(lowF, st.lowGain);
            end else begin
                next_st.lowX    = '0;
                next_st.lowY    = '0;
                next_st.lowGain = initGain(cfg.lowCurve);
                next_st.lowOut  = '0;
            end
            // middle highpass history, cleared while bypassed
            if (mhOn) begin
                next_st.mhX = sampleIn;
                next_st.mhY = hpF;
            end else begin
                next_st.mhX = '0;
                next_st.mhY = '0;
            end
            // middle lowpass history, cleared while bypassed
            if (mlOn) begin
                next_st.mlX = hpF;
                next_st.mlY = lpF;
            end else begin
                next_st.mlX = '0;
                next_st.mlY = '0;
            end
            // middle curve only while a filter runs
            if (midOn) begin
                next_st.midGain = step(st.midGain, target(level(lpF), cfg.midCurve));
                next_st.midOut  = applyGain(lpF, st.midGain);
            end else begin
                next_st.midGain = initGain(cfg.midCurve);
                next_st.midOut  = sampleIn;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state
    assign lowOut   = st.lowOut;
    assign midOut   = st.midOut;
    assign outValid = st.outValid;

endmodule : band_dynamic_volume

// File: hdl/band_dvol_controller.sv
// controller end: axi4-lite registers driving the band stage setup
// assumes an axi4-lite master on clk, one write and one read at a time
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`include "band_dvol_cfg.svh"
module band_dvol_controller (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // axi4-lite slave
    input  wire logic [`AXI_AW-1:0]   awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [`AXI_AW-1:0]   araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // setup towards the band stage
    band_dvol_if.ctrl                 cfg
);

    // pending group a register belongs to
    function automatic logic [`NGRP-1:0] grp(input logic [3:0] ix);
        case (ix)
            `IX_LA, `IX_LB:                 return `NGRP'(1) << `PG_LOW;
            `IX_HA, `IX_HB:                 return `NGRP'(1) << `PG_MHP;
            `IX_MA, `IX_MB:                 return `NGRP'(1) << `PG_MLP;
            `IX_LP12, `IX_LP3, `IX_LS:      return `NGRP'(1) << `PG_LCRV;
            `IX_MP12, `IX_MP3, `IX_MS:      return `NGRP'(1) << `PG_MCRV;
            default:                        return '0;
        endcase
    endfunction : grp

    // raise a pole coefficient to its least cutoff
    function automatic logic [31:0] clampB(input logic [31:0] v, input logic [13:0] lo);
        return ($signed(v[`COEF_W-1:0]) < $signed(lo)) ? 32'(lo) : 32'(v[`COEF_W-1:0]);
    endfunction : clampB

    // points in range and non-decreasing
    function automatic logic ordered(input logic [31:0] a, input logic [31:0] b);
        band_dvol_pkg::pt12_t p;
        band_dvol_pkg::pt3_t  q;
        p = band_dvol_pkg::pt12_t'(a[$bits(band_dvol_pkg::pt12_t)-1:0]);
        q = band_dvol_pkg::pt3_t'(b[$bits(band_dvol_pkg::pt3_t)-1:0]);
        return (p.x2 <= `PT_MAX) && (p.y2 <= `PT_MAX)
            && (p.x1 <= p.x2) && (p.x2 <= 6'(q.x3))
            && (p.y1 <= p.y2) && (p.y2 <= 6'(q.y3));
    endfunction : ordered

    band_dvol_pkg::ctl_state_t s;
    band_dvol_pkg::ctl_state_t next_s;
    band_dvol_pkg::ctrl_t      lc;
    logic                      gate;
    logic                      setErr;
    logic                      clrErr;
    logic [`AXI_AW-3:0]        wix;
    logic [`AXI_AW-3:0]        rix;

    // bus handling and guarded commits
    always_comb begin
        next_s = s;
        lc     = band_dvol_pkg::ctrl_t'(s.live[`IX_CTRL][$bits(band_dvol_pkg::ctrl_t)-1:0]);
        gate   = lc.dac & lc.comp;
        setErr = 1'b0;
        clrErr = 1'b0;
        // whole word index, so high addresses cannot alias low registers
        wix    = s.awaddr[`AXI_AW-1:2];
        rix    = araddr[`AXI_AW-1:2];
        // address and data taken in either order
        if (awvalid && s.awready) begin
            next_s.awGot  = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.wGot  = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // coefficients reach the stage only while it is gated off
        if (s.pend[`PG_LOW] && !(gate && lc.lowEn)) begin
            next_s.live[`IX_LA]  = s.shadow[`IX_LA];
            next_s.live[`IX_LB]  = clampB(s.shadow[`IX_LB], `LOW_B_MIN);
            next_s.pend[`PG_LOW] = 1'b0;
        end
        if (s.pend[`PG_MHP] && !(gate && lc.mhpEn)) begin
            next_s.live[`IX_HA]  = s.shadow[`IX_HA];
            next_s.live[`IX_HB]  = clampB(s.shadow[`IX_HB], `MHP_B_MIN);
            next_s.pend[`PG_MHP] = 1'b0;
        end
        if (s.pend[`PG_MLP] && !(gate && lc.mlpEn)) begin
            next_s.live[`IX_MA]  = s.shadow[`IX_MA];
            next_s.live[`IX_MB]  = clampB(s.shadow[`IX_MB], `MLP_B_MIN);
            next_s.pend[`PG_MLP] = 1'b0;
        end
        // curves held back while misordered
        if (s.pend[`PG_LCRV] && !gate) begin
            if (ordered(s.shadow[`IX_LP12], s.shadow[`IX_LP3])) begin
                next_s.live[`IX_LP12] = s.shadow[`IX_LP12];
                next_s.live[`IX_LP3]  = s.shadow[`IX_LP3];
                next_s.live[`IX_LS]   = s.shadow[`IX_LS];
                next_s.pend[`PG_LCRV] = 1'b0;
            end else begin
                setErr = 1'b1;
            end
        end
        if (s.pend[`PG_MCRV] && (!gate || !(lc.mhpEn || lc.mlpEn))) begin
            if (ordered(s.shadow[`IX_MP12], s.shadow[`IX_MP3])) begin
                next_s.live[`IX_MP12] = s.shadow[`IX_MP12];
                next_s.live[`IX_MP3]  = s.shadow[`IX_MP3];
                next_s.live[`IX_MS]   = s.shadow[`IX_MS];
                next_s.pend[`PG_MCRV] = 1'b0;
            end else begin
                setErr = 1'b1;
            end
        end
        // register write once both halves are in
        if (s.awGot && s.wGot && !s.bvalid) begin
            next_s.awGot  = 1'b0;
            next_s.wGot   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `RESP_OK;
            if (wix == `IX_STATUS) begin
                clrErr = s.wstrb[0] && s.wdata[`ERR_BIT];
            end else if (wix < `NREG) begin
                for (int b = 0; b < 4; b++) begin
                    if (s.wstrb[b]) begin
                        next_s.shadow[wix][b*8 +: 8] = s.wdata[b*8 +: 8];
                    end
                end
                next_s.pend = next_s.pend | grp(wix[3:0]);
                if (wix == `IX_CTRL) begin
                    next_s.live[`IX_CTRL] = next_s.shadow[`IX_CTRL];
                end
            end else begin
                next_s.bresp = `RESP_SLVERR;
            end
        end
        // a new order error wins over a clear
        next_s.orderErr = (s.orderErr && !clrErr) || setErr;
        next_s.awready  = !next_s.awGot && !next_s.bvalid;
        next_s.wready   = !next_s.wGot && !next_s.bvalid;
        // read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `RESP_OK;
            if (rix == `IX_STATUS) begin
                next_s.rdata = 32'({s.orderErr, s.pend});
            end else if (rix < `NREG) begin
                next_s.rdata = s.shadow[rix];
            end else begin
                next_s.rdata = '0;
                next_s.rresp = `RESP_SLVERR;
            end
        end
        next_s.arready = !next_s.rvalid;
    end

    // state register, ready lines high out of reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s         <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // bus outputs from the state
    assign awready = s.awready;
    assign wready  = s.wready;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = s.arready;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;
    // live setup towards the stage
    assign cfg.ctl      = lc;
    assign cfg.lowA     = s.live[`IX_LA][`COEF_W-1:0];
    assign cfg.lowB     = s.live[`IX_LB][`COEF_W-1:0];
    assign cfg.mhA      = s.live[`IX_HA][`COEF_W-1:0];
    assign cfg.mhB      = s.live[`IX_HB][`COEF_W-1:0];
    assign cfg.mlA      = s.live[`IX_MA][`COEF_W-1:0];
    assign cfg.mlB      = s.live[`IX_MB][`COEF_W-1:0];
    assign cfg.lowCurve = {s.live[`IX_LS][$bits(band_dvol_pkg::slope_t)-1:0],
                           s.live[`IX_LP3][$bits(band_dvol_pkg::pt3_t)-1:0],
                           s.live[`IX_LP12][$bits(band_dvol_pkg::pt12_t)-1:0]};
    assign cfg.midCurve = {s.live[`IX_MS][$bits(band_dvol_pkg::slope_t)-1:0],
                           s.live[`IX_MP3][$bits(band_dvol_pkg::pt3_t)-1:0],
                           s.live[`IX_MP12][$bits(band_dvol_pkg::pt12_t)-1:0]};

endmodule : band_dvol_controller

// File: testbench/band_dvol_sva.sv
// checker: audio and setup timing of both ends
// assumes one clk domain, placed beside the carrier
`include "band_dvol_cfg.svh"
module band_dvol_sva (
    input wire logic                    clk, arst_n, sampleTick, outValid,
    input wire band_dvol_pkg::ctrl_t    ctl,
    input wire band_dvol_pkg::coef_t    lowA, lowB, mhA, mhB, mlA, mlB,
    input wire band_dvol_pkg::curve_t   lowCurve, midCurve,
    input wire band_dvol_pkg::sample_t  sampleIn, lowOut, midOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ****
    // gate terms
    // ****
    wire gate = ctl.dac & ctl.comp;
    wire midOn = gate & (ctl.mhpEn | ctl.mlpEn);
    a_low_zero: assert property (outValid && !$past(gate & ctl.lowEn) |-> lowOut == '0)
        else $error("low band not silent");
    a_mid_pass: assert property (outValid && !$past(midOn) |-> midOut == $past(sampleIn))
        else $error("mid band not passed");
    a_valid_tick: assert property (outValid == $past(sampleTick))
        else $error("valid not after tick");
    a_low_coef: assert property (!$stable({lowA, lowB}) |-> !$past(gate & ctl.lowEn))
        else $error("low coef changed while on");
    a_mhp_coef: assert property (!$stable({mhA, mhB}) |-> !$past(gate & ctl.mhpEn))
        else $error("hpf coef changed while on");
    a_mlp_coef: assert property (!$stable({mlA, mlB}) |-> !$past(gate & ctl.mlpEn))
        else $error("lpf coef changed while on");
    a_mid_curve: assert property (!$stable(midCurve) |-> !$past(midOn))
        else $error("mid curve changed while on");
    a_curve_order: assert property (lowCurve.p12.x1 <= lowCurve.p12.x2
        && lowCurve.p12.x2 <= lowCurve.p3.x3 && lowCurve.p12.y2 <= lowCurve.p3.y3)
        else $error("low curve out of order");
    c_low_on: cover property (outValid && lowOut != '0);
    c_mid_on: cover property (midOn);
    c_coef: cover property (!$stable(lowB));
endmodule : band_dvol_sva

// File: testbench/tb_top.sv
// bench: both ends on one carrier, axi4-lite and audio driven here
// assumes the design files are compiled first
`include "band_dvol_cfg.svh"
`define CHK(n, a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, sampleTick = 0;
    logic bready = 1, rready = 1, awready, wready, bvalid, arready, rvalid, outValid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    band_dvol_pkg::sample_t sampleIn = 0, lowOut, midOut, x;
    int checked = 0, err_total = 0;
    integer seed = 75886;
    band_dvol_if bus ();
    band_dvol_controller band_dvol_controller_inst (.clk, .arst_n, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cfg(bus));
    band_dynamic_volume band_dynamic_volume_inst (.clk, .arst_n, .cfg(bus), .sampleIn,
        .sampleTick, .lowOut, .midOut, .outValid);
    band_dvol_sva band_dvol_sva_inst (.clk, .arst_n, .sampleTick, .outValid, .ctl(bus.ctl),
        .lowA(bus.lowA), .lowB(bus.lowB), .mhA(bus.mhA), .mhB(bus.mhB), .mlA(bus.mlA),
        .mlB(bus.mlB), .lowCurve(bus.lowCurve), .midCurve(bus.midCurve), .sampleIn,
        .lowOut, .midOut);
    // ****
    // clock, bus and audio tasks
    // ****
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        `CHK("bresp", bresp, r)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        `CHK("rdata", rdata, e)
        `CHK("rresp", rresp, r)
    endtask : rd
    task automatic tk(input band_dvol_pkg::sample_t el, input band_dvol_pkg::sample_t em);
        sampleIn <= x; sampleTick <= 1'b1;
        @(posedge clk);
        sampleTick <= 1'b0;
        #1;
        `CHK("lowOut", lowOut, el)
        `CHK("midOut", midOut, em)
        @(posedge clk);
    endtask : tk
    // one filter on at a half gain, zero pole, same sample twice
    task automatic ft(input logic [7:0] r, input logic [4:0] c, input logic lo, hp);
        wr(8'h00, 32'h0, `RESP_OK);
        wr(r, 32'h1000, `RESP_OK);
        wr(r + 8'h04, 32'h0, `RESP_OK);
        wr(8'h00, {27'h0, c}, `RESP_OK);
        repeat (2) @(posedge clk);
        x = $random(seed) & 32'h3ffffe;
        tk(lo ? x >>> 1 : '0, lo ? x : x >>> 1);
        tk(lo ? x : '0, lo ? x : (hp ? '0 : x));
    endtask : ft
    // first section output on a fresh history, then a gain shift
    function automatic band_dvol_pkg::sample_t scaled(input longint v, a, input int sh);
        return band_dvol_pkg::sample_t'((v * a) >>> sh);
    endfunction : scaled
    task automatic end_of_test();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h0, `RESP_OK);
        rd(8'h38, 32'h0, `RESP_SLVERR);
        wr(8'h38, 32'h1, `RESP_SLVERR);
        rd(8'h74, 32'h0, `RESP_SLVERR);
        repeat (8) begin
            x = $random(seed);
            tk('0, x);
        end
        wr(8'h08, 32'h2000, `RESP_OK);
        rd(8'h08, 32'h2000, `RESP_OK);
        `CHK("lowB", bus.lowB, `LOW_B_MIN)
        ft(8'h04, 5'h19, 1'b1, 1'b0);
        ft(8'h0c, 5'h1a, 1'b0, 1'b1);
        ft(8'h14, 5'h1c, 1'b0, 1'b0);
        wr(8'h00, 32'h19, `RESP_OK);
        wr(8'h04, 32'h0800, `RESP_OK);
        rd(8'h34, 32'h1, `RESP_OK);
        `CHK("lowA", bus.lowA, 14'h1000)
        wr(8'h00, 32'h0, `RESP_OK);
        wr(8'h20, 32'h3, `RESP_OK);
        wr(8'h1c, 32'h1002, `RESP_OK);
        rd(8'h34, 32'h28, `RESP_OK);
        wr(8'h1c, 32'h2001, `RESP_OK);
        wr(8'h34, 32'h20, `RESP_OK);
        rd(8'h34, 32'h0, `RESP_OK);
        `CHK("lowA", bus.lowA, 14'h0800)
        wr(8'h24, 32'h4, `RESP_OK);
        x = $random(seed) & 32'h3ffff8;
        tk('0, x);
        wr(8'h00, 32'h19, `RESP_OK);
        tk(scaled(x, 14'h0800, `COEF_FRAC + 1), x);
        end_of_test();
    end
endmodule : tb_top
